//--- core/oxb_pkg.sv
package oxb_pkg;

  // register byte offsets
  localparam logic [7:0] OXB_OFS_CTRL = 8'h00;
  localparam logic [7:0] OXB_OFS_LOW = 8'h04;
  localparam logic [7:0] OXB_OFS_HIGH = 8'h08;
  localparam logic [7:0] OXB_OFS_PAIR = 8'h0C;
  localparam logic [7:0] OXB_OFS_SETTLE = 8'h10;
  localparam logic [7:0] OXB_OFS_STATUS = 8'h14;

  // control register fields
  localparam int OXB_CTRL_MODE_LSB = 0;
  localparam int OXB_CTRL_TOGGLE_BIT = 2;

  // pin modes
  localparam logic [1:0] OXB_MODE_OFF = 2'h0;
  localparam logic [1:0] OXB_MODE_SINGLE2 = 2'h1;
  localparam logic [1:0] OXB_MODE_DUAL2 = 2'h2;
  localparam logic [1:0] OXB_MODE_INVALID = 2'h3;

  // choice codes: 0..3 name obs_rx_1..4, this one is the invalid code
  localparam logic [2:0] OXB_CHOICE_INVALID = 3'h4;

  // settling delay: register holds 0..16, wait is value plus 2 cycles
  localparam logic [4:0] OXB_SETTLE_MAX = 5'h10;
  localparam logic [4:0] OXB_SETTLE_BASE = 5'h02;

  // values after reset
  localparam logic [1:0] OXB_RST_MODE = OXB_MODE_OFF;
  localparam logic OXB_RST_TOGGLE = 1'b0;
  localparam logic [1:0] OXB_RST_LOW = 2'h0;
  localparam logic [1:0] OXB_RST_HIGH = 2'h1;
  localparam logic [1:0] OXB_RST_PAIR = 2'h0;
  localparam logic [4:0] OXB_RST_SETTLE = 5'h00;

  // sample width on every path
  localparam int OXB_SAMPLE_W = 16;

  // which source feeds the serializer
  typedef enum logic [1:0] {
    OXB_PATH_IDLE,
    OXB_PATH_RX,
    OXB_PATH_ORX
  } oxb_path_e;

  typedef struct packed {
    logic valid;
    logic [OXB_SAMPLE_W-1:0] data;
  } oxb_sample_s;

endpackage

//--- core/oxb_pin_sync.sv
`timescale 1ns/1ns
module oxb_pin_sync import oxb_pkg::*; #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pins_async,
  output logic [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  initial begin
    if (WIDTH < 1) $error("oxb_pin_sync: WIDTH must be at least 1");
  end

  // two stages; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;

endmodule

//--- core/oxb_xbar.sv
`timescale 1ns/1ns
module oxb_xbar import oxb_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // path control
  input wire logic toggle_mode,
  input wire logic rx_enable,
  input wire logic [3:0] orx_enable,
  // sample sources
  input wire oxb_sample_s rx_sample,
  input wire oxb_sample_s [3:0] orx_sample,
  // serializer side
  output oxb_sample_s ser_sample,
  output oxb_path_e ser_path
);

  // lowest enabled observation channel wins the shared serializer
  function automatic logic [1:0] first_set(input logic [3:0] m);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) idx = 2'(i);
    end
    return idx;
  endfunction

  oxb_sample_s sample_d;
  oxb_path_e path_d;
  logic orx_any;

  assign orx_any = |orx_enable;

  // path choice; observation takes priority when both ask in default mode
  always_comb begin
    sample_d = '0;
    path_d = OXB_PATH_IDLE;
    if (orx_any) begin
      sample_d = orx_sample[first_set(orx_enable)];
      path_d = OXB_PATH_ORX;
    end else if (toggle_mode || rx_enable) begin
      sample_d = rx_sample;
      path_d = OXB_PATH_RX;
    end
  end

  // registered so the serializer never sees a half-switched sample
  always_ff @(posedge clock) begin
    if (srst) begin
      ser_sample <= '0;
      ser_path <= OXB_PATH_IDLE;
    end else begin
      ser_sample <= sample_d;
      ser_path <= path_d;
    end
  end

endmodule

//--- core/oxb_top.sv
`timescale 1ns/1ns
module oxb_top import oxb_pkg::*; #(
  parameter int SAMPLE_W = OXB_SAMPLE_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // control pins from the baseband controller
  input wire logic orx_ctrl_a,
  input wire logic orx_ctrl_b,
  input wire logic rx_enable_pin,
  // sample sources
  input wire oxb_sample_s rx_sample,
  input wire oxb_sample_s [3:0] orx_sample,
  // observation receiver enables
  output logic [3:0] orx_enable,
  // serializer side
  output oxb_sample_s ser_sample,
  output oxb_path_e ser_path
);

  initial begin
    if (SAMPLE_W != OXB_SAMPLE_W) $error("oxb_top: SAMPLE_W must equal the package sample width");
  end

  typedef enum logic {
    OXB_ST_STABLE,
    OXB_ST_SETTLE
  } oxb_settle_e;

  // one-hot of a two-bit receiver index
  function automatic logic [3:0] onehot(input logic [1:0] idx);
    return 4'h1 << idx;
  endfunction

  // codes 0..3 are receivers, anything else is refused
  function automatic logic choice_ok(input logic [31:0] wd);
    return wd[31:2] == 30'h0;
  endfunction

  // configuration registers
  logic [1:0] mode_q;
  logic toggle_q;
  logic [1:0] low_q;
  logic [1:0] high_q;
  logic [1:0] pair_q;
  logic [4:0] settle_q;

  // pin path
  logic [2:0] pins_sync;
  logic [1:0] ab_sync;
  logic rx_en_sync;
  logic [1:0] cand_q;
  logic [1:0] applied_q;
  logic [4:0] cnt_q;
  oxb_settle_e st_q;
  logic [4:0] wait_last;
  logic [3:0] orx_en_d;
  logic [31:0] rdata_d;

  oxb_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .pins_async({rx_enable_pin, orx_ctrl_b, orx_ctrl_a}),
    .pins_sync(pins_sync)
  );

  assign ab_sync = pins_sync[1:0];
  assign rx_en_sync = pins_sync[2];

  // pin mode and crossbar mode; the invalid mode code leaves the mode alone
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= OXB_RST_MODE;
      toggle_q <= OXB_RST_TOGGLE;
    end else if (reg_wr && reg_addr == OXB_OFS_CTRL) begin
      if (reg_wdata[OXB_CTRL_MODE_LSB +: 2] != OXB_MODE_INVALID) begin
        mode_q <= reg_wdata[OXB_CTRL_MODE_LSB +: 2];
      end
      toggle_q <= reg_wdata[OXB_CTRL_TOGGLE_BIT];
    end
  end

  // choice for select pin B low
  always_ff @(posedge clock) begin
    if (srst) begin
      low_q <= OXB_RST_LOW;
    end else if (reg_wr && reg_addr == OXB_OFS_LOW && choice_ok(reg_wdata)) begin
      low_q <= reg_wdata[1:0];
    end
  end

  // choice for select pin B high
  always_ff @(posedge clock) begin
    if (srst) begin
      high_q <= OXB_RST_HIGH;
    end else if (reg_wr && reg_addr == OXB_OFS_HIGH && choice_ok(reg_wdata)) begin
      high_q <= reg_wdata[1:0];
    end
  end

  // dual-mode pair
  always_ff @(posedge clock) begin
    if (srst) begin
      pair_q <= OXB_RST_PAIR;
    end else if (reg_wr && reg_addr == OXB_OFS_PAIR && choice_ok(reg_wdata)) begin
      pair_q <= reg_wdata[1:0];
    end
  end

  // settling delay; values past the range are ignored rather than clipped
  always_ff @(posedge clock) begin
    if (srst) begin
      settle_q <= OXB_RST_SETTLE;
    end else if (reg_wr && reg_addr == OXB_OFS_SETTLE && reg_wdata[31:5] == 27'h0
                 && reg_wdata[4:0] <= OXB_SETTLE_MAX) begin
      settle_q <= reg_wdata[4:0];
    end
  end

  assign wait_last = 5'(settle_q + OXB_SETTLE_BASE - 5'h01);

  // pin levels are taken only after they held still for the settling wait
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= OXB_ST_STABLE;
      cand_q <= 2'h0;
      cnt_q <= 5'h00;
      applied_q <= 2'h0;
    end else begin
      unique case (st_q)
        OXB_ST_STABLE: begin
          if (ab_sync != applied_q) begin
            st_q <= OXB_ST_SETTLE;
            cand_q <= ab_sync;
            cnt_q <= 5'h00;
          end
        end
        OXB_ST_SETTLE: begin
          if (ab_sync != cand_q) begin
            cand_q <= ab_sync; // a bounce restarts the wait
            cnt_q <= 5'h00;
          end else if (cnt_q == wait_last) begin
            applied_q <= cand_q;
            st_q <= OXB_ST_STABLE;
          end else begin
            cnt_q <= 5'(cnt_q + 5'h01);
          end
        end
      endcase
    end
  end

  // enable decode from the settled pin levels
  always_comb begin
    orx_en_d = 4'h0;
    unique case (mode_q)
      OXB_MODE_SINGLE2: begin
        if (!applied_q[0]) begin
          orx_en_d = 4'h0;
        end else if (applied_q[1]) begin
          orx_en_d = onehot(high_q);
        end else begin
          orx_en_d = onehot(low_q);
        end
      end
      OXB_MODE_DUAL2: begin
        // pin A enables the rx 1/2 member, pin B the rx 3/4 member
        if (applied_q[0]) orx_en_d = orx_en_d | onehot({1'b0, pair_q[1]});
        if (applied_q[1]) orx_en_d = orx_en_d | onehot({1'b1, pair_q[0]});
      end
      default: orx_en_d = 4'h0;
    endcase
  end

  // enables leave on a flop, one clock after the decode
  always_ff @(posedge clock) begin
    if (srst) begin
      orx_enable <= 4'h0;
    end else begin
      orx_enable <= orx_en_d;
    end
  end

  // crossbar follows the registered enables, so the path moves one clock after the enable
  oxb_xbar u_xbar (
    .clock(clock),
    .srst(srst),
    .toggle_mode(toggle_q),
    .rx_enable(rx_en_sync),
    .orx_enable(orx_enable),
    .rx_sample(rx_sample),
    .orx_sample(orx_sample),
    .ser_sample(ser_sample),
    .ser_path(ser_path)
  );

  // read decode; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0;
    unique case (reg_addr)
      OXB_OFS_CTRL: rdata_d = {29'h0, toggle_q, mode_q};
      OXB_OFS_LOW: rdata_d = {30'h0, low_q};
      OXB_OFS_HIGH: rdata_d = {30'h0, high_q};
      OXB_OFS_PAIR: rdata_d = {30'h0, pair_q};
      OXB_OFS_SETTLE: rdata_d = {27'h0, settle_q};
      OXB_OFS_STATUS: rdata_d = {22'h0, rx_en_sync, ab_sync, st_q == OXB_ST_SETTLE, ser_path, orx_enable};
      default: rdata_d = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

//--- verif/oxb_checker.sv
`timescale 1ns/1ns
module oxb_checker import oxb_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // pins
  input wire logic orx_ctrl_a,
  input wire logic orx_ctrl_b,
  input wire logic rx_enable_pin,
  // samples and results
  input wire oxb_sample_s rx_sample,
  input wire oxb_sample_s [3:0] orx_sample,
  input wire logic [3:0] orx_enable,
  input wire oxb_sample_s ser_sample,
  input wire oxb_path_e ser_path
);
  logic [1:0] mode_q, pins_q, low_q, high_q, pair_q, lo;
  logic tog_q;
  logic [4:0] set_q;
  logic [5:0] quiet_q, wq_q, age_q;
  logic [3:0] exp_en;
  // register mirror; refused codes leave the old value
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= OXB_RST_MODE;
      tog_q <= OXB_RST_TOGGLE;
      low_q <= OXB_RST_LOW;
      high_q <= OXB_RST_HIGH;
      pair_q <= OXB_RST_PAIR;
      set_q <= OXB_RST_SETTLE;
    end else if (reg_wr) begin
      if (reg_addr == OXB_OFS_CTRL) begin
        tog_q <= reg_wdata[OXB_CTRL_TOGGLE_BIT];
        if (reg_wdata[1:0] != OXB_MODE_INVALID) mode_q <= reg_wdata[1:0];
      end
      if (reg_wdata < 32'h4) begin
        if (reg_addr == OXB_OFS_LOW) low_q <= reg_wdata[1:0];
        if (reg_addr == OXB_OFS_HIGH) high_q <= reg_wdata[1:0];
        if (reg_addr == OXB_OFS_PAIR) pair_q <= reg_wdata[1:0];
      end
      if (reg_addr == OXB_OFS_SETTLE && reg_wdata <= 32'h10) set_q <= reg_wdata[4:0];
    end
  end
  // cycles since pins moved, since last write, since reset
  always_ff @(posedge clock) begin
    pins_q <= {orx_ctrl_b, orx_ctrl_a};
    quiet_q <= (srst || pins_q != {orx_ctrl_b, orx_ctrl_a}) ? 6'h00 : quiet_q + {5'h00, quiet_q != 6'h3F};
    wq_q <= (srst || reg_wr) ? 6'h00 : wq_q + {5'h00, wq_q != 6'h3F};
    age_q <= srst ? 6'h00 : age_q + {5'h00, age_q != 6'h3F};
  end
  // expected enables from settled pins, lowest enabled channel
  always_comb begin
    exp_en = 4'h0;
    lo = 2'h0;
    if (mode_q == OXB_MODE_SINGLE2 && pins_q[0]) exp_en[pins_q[1] ? high_q : low_q] = 1'b1;
    if (mode_q == OXB_MODE_DUAL2 && pins_q[0]) exp_en[{1'b0, pair_q[1]}] = 1'b1;
    if (mode_q == OXB_MODE_DUAL2 && pins_q[1]) exp_en[{1'b1, pair_q[0]}] = 1'b1;
    for (int i = 3; i >= 0; i--)
      if (orx_enable[i]) lo = i[1:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // a pin-driven change, not one caused by a write
  sequence s_applied;
    $changed(orx_enable) && wq_q > quiet_q && age_q > 6'h02;
  endsequence
  AST_SETTLE_TIME: assert property (s_applied |-> quiet_q == {1'b0, set_q} + 6'h05)
    else $error("enable changed off the settling time");
  AST_PIN_STEADY: assert property (quiet_q > {1'b0, set_q} + 6'h05 && wq_q > 6'h02 && age_q > 6'h08 |-> orx_enable == exp_en)
    else $error("enables differ from the settled pin choice");
  AST_SINGLE_ONE: assert property (mode_q == OXB_MODE_SINGLE2 && wq_q > 6'h02 |-> $countones(orx_enable) <= 1)
    else $error("more than one receiver in single mode");
  AST_ORX_ROUTE: assert property (|orx_enable |=> ser_path == OXB_PATH_ORX && ser_sample == $past(orx_sample[lo]))
    else $error("enabled observation channel not routed");
  AST_TOGGLE_RX: assert property (tog_q && orx_enable == 4'h0 |=> ser_path == OXB_PATH_RX && ser_sample == $past(rx_sample))
    else $error("receiver not reconnected in toggling mode");
  AST_DEFAULT_RX: assert property (!tog_q && orx_enable == 4'h0 && age_q > 6'h03 && $past(rx_enable_pin, 2) |=> ser_path == OXB_PATH_RX)
    else $error("receiver not routed while its pin is active");
  AST_DEFAULT_IDLE: assert property (!tog_q && orx_enable == 4'h0 && age_q > 6'h03 && !$past(rx_enable_pin, 2) |=> ser_path == OXB_PATH_IDLE && ser_sample == '0)
    else $error("path not idle with nothing enabled");
  AST_RDATA_IDLE: assert property (age_q > 6'h01 && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind oxb_top oxb_checker u_chk (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .orx_ctrl_a(orx_ctrl_a), .orx_ctrl_b(orx_ctrl_b),
  .rx_enable_pin(rx_enable_pin), .rx_sample(rx_sample), .orx_sample(orx_sample), .orx_enable(orx_enable),
  .ser_sample(ser_sample), .ser_path(ser_path));

//--- verif/oxb_ctrl_model.sv
`timescale 1ns/1ns
module oxb_ctrl_model import oxb_pkg::*; (
  // clock
  input wire logic clock,
  // requested levels {rx enable, b, a}
  input wire logic [2:0] want,
  // pins and sample sources
  output logic orx_ctrl_a = 1'b0,
  output logic orx_ctrl_b = 1'b0,
  output logic rx_enable_pin = 1'b0,
  output oxb_sample_s rx_sample,
  output oxb_sample_s [3:0] orx_sample
);
  logic [15:0] cnt_q = 16'h0000;
  // pins move just after an edge, as a registered controller output would
  always_ff @(posedge clock) begin
    {rx_enable_pin, orx_ctrl_b, orx_ctrl_a} <= want;
    cnt_q <= cnt_q + 16'h0001;
  end
  // every source changes each cycle so a stale route shows
  always_comb begin
    rx_sample = {1'b1, cnt_q};
    for (int i = 0; i < 4; i++)
      orx_sample[i] = {1'b1, cnt_q + 16'((i + 1) * 4096)};
  end
endmodule

//--- verif/tb_obs_rx_select_and_adc_crossbar.sv
`timescale 1ns/1ns
module tb_obs_rx_select_and_adc_crossbar import oxb_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, a, b, rxen;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] want = 3'h0;
  logic [3:0] orx_enable;
  oxb_sample_s rxs, sers;
  oxb_sample_s [3:0] orxs;
  oxb_path_e path;
  int fail_count = 0, num_checks = 0;
  always #20 clock = ~clock;
  oxb_ctrl_model u_ctrl (.clock(clock), .want(want), .orx_ctrl_a(a), .orx_ctrl_b(b), .rx_enable_pin(rxen),
    .rx_sample(rxs), .orx_sample(orxs));
  oxb_top #(.SAMPLE_W(16)) DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .orx_ctrl_a(a), .orx_ctrl_b(b), .rx_enable_pin(rxen),
    .rx_sample(rxs), .orx_sample(orxs), .orx_enable(orx_enable), .ser_sample(sers), .ser_path(path));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe drops at the edge that takes it, so writes may follow back to back
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", e, reg_rdata);
  endtask
  // settled pins: wait covers settle plus seven edges and the model's own edge
  task automatic pins(input logic [2:0] w, input int n, input logic [3:0] e, input oxb_path_e p);
    want <= w;
    repeat (n) @(posedge clock);
    #1;
    check("orx_enable", {28'h0, e}, {28'h0, orx_enable});
    check("ser_path", {30'h0, p}, {30'h0, path});
    // every source sample is valid, so only an idle path may show an empty word
    check("ser_sample_valid", {31'h0, p != OXB_PATH_IDLE}, {31'h0, sers.valid});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(OXB_OFS_CTRL, {29'h0, OXB_RST_TOGGLE, OXB_RST_MODE});
    rd(OXB_OFS_HIGH, {30'h0, OXB_RST_HIGH});
    rd(OXB_OFS_PAIR, {30'h0, OXB_RST_PAIR});
    wr(OXB_OFS_LOW, 32'h2);
    wr(OXB_OFS_LOW, 32'h5);
    rd(OXB_OFS_LOW, 32'h2);
    wr(OXB_OFS_HIGH, 32'h3);
    wr(OXB_OFS_HIGH, 32'h4);
    rd(OXB_OFS_HIGH, 32'h3);
    wr(OXB_OFS_SETTLE, 32'h11);
    rd(OXB_OFS_SETTLE, 32'h0);
    wr(8'h18, 32'hF);
    rd(8'h18, 32'h0);
    wr(OXB_OFS_CTRL, 32'h1);
    wr(OXB_OFS_CTRL, 32'h3);
    rd(OXB_OFS_CTRL, 32'h1);
    pins(3'h1, 8, 4'h4, OXB_PATH_ORX);
    rd(OXB_OFS_STATUS, 32'hA4);
    pins(3'h3, 8, 4'h8, OXB_PATH_ORX);
    pins(3'h2, 8, 4'h0, OXB_PATH_IDLE);
    wr(OXB_OFS_SETTLE, 32'h10);
    pins(3'h1, 10, 4'h0, OXB_PATH_IDLE);
    pins(3'h1, 20, 4'h4, OXB_PATH_ORX);
    pins(3'h3, 6, 4'h4, OXB_PATH_ORX);
    pins(3'h1, 30, 4'h4, OXB_PATH_ORX);
    wr(OXB_OFS_SETTLE, 32'h0);
    wr(OXB_OFS_CTRL, 32'h2);
    for (int p = 0; p < 4; p++) begin
      wr(OXB_OFS_PAIR, p);
      pins(3'h3, 8, 4'(1 << p[1]) | 4'(4 << p[0]), OXB_PATH_ORX);
      pins(3'h0, 8, 4'h0, OXB_PATH_IDLE);
    end
    wr(OXB_OFS_PAIR, 32'h7);
    rd(OXB_OFS_PAIR, 32'h3);
    pins(3'h4, 8, 4'h0, OXB_PATH_RX);
    pins(3'h6, 8, 4'h8, OXB_PATH_ORX);
    wr(OXB_OFS_CTRL, 32'h6);
    pins(3'h0, 8, 4'h0, OXB_PATH_RX);
    pins(3'h1, 8, 4'h2, OXB_PATH_ORX);
    pins(3'h5, 8, 4'h2, OXB_PATH_ORX);
    pins(3'h4, 8, 4'h0, OXB_PATH_RX);
    test_done();
  end
endmodule
